// File: rtl/sbt_tap.sv
module sbt_tap (
	input wire logic clock, // System clock
	input wire logic reset, // Power-up reset, sync high
	input wire logic tck, // Test clock
	input wire logic tms, // Test mode select
	input wire logic tdi, // Test data in
	output logic tdo, // Test data out
	output logic tdo_oe_n, // TDO enable, low drives
	input wire logic [sbt_pkg::SBT_BSR_W-1:0] ring_in, // I/O ring levels
	output sbt_pkg::sbt_ring_t ring_test, // Test vector and drive
	output sbt_pkg::sbt_state_t tap_state // Controller state
);
	import sbt_pkg::*;

	// ==========================================================
	// Power-up reset into the test clock domain
	logic por_meta;
	logic por_sync;
	always_ff @(posedge tck)
	begin
		por_meta <= reset;
		por_sync <= por_meta;
	end

	// ==========================================================
	// Ring input synchronisers
	logic [SBT_BSR_W-1:0] ring_meta;
	logic [SBT_BSR_W-1:0] ring_sync;
	always_ff @(posedge tck)
	begin
		ring_meta <= ring_in;
		ring_sync <= ring_meta;
	end

	// ==========================================================
	// Controller state machine
	sbt_state_t state;
	sbt_state_t next_state;

	// Next state from TMS only
	always_comb
	begin
		next_state = state;
		unique case (state)
			SBT_TLR: next_state = tms ? SBT_TLR : SBT_RTI;
			SBT_RTI: next_state = tms ? SBT_SEL_DR : SBT_RTI;
			SBT_SEL_DR: next_state = tms ? SBT_SEL_IR : SBT_CAP_DR;
			SBT_CAP_DR: next_state = tms ? SBT_EX1_DR : SBT_SHF_DR;
			SBT_SHF_DR: next_state = tms ? SBT_EX1_DR : SBT_SHF_DR;
			SBT_EX1_DR: next_state = tms ? SBT_UPD_DR : SBT_PAU_DR;
			SBT_PAU_DR: next_state = tms ? SBT_EX2_DR : SBT_PAU_DR;
			SBT_EX2_DR: next_state = tms ? SBT_UPD_DR : SBT_SHF_DR;
			SBT_UPD_DR: next_state = tms ? SBT_SEL_DR : SBT_RTI;
			SBT_SEL_IR: next_state = tms ? SBT_TLR : SBT_CAP_IR;
			SBT_CAP_IR: next_state = tms ? SBT_EX1_IR : SBT_SHF_IR;
			SBT_SHF_IR: next_state = tms ? SBT_EX1_IR : SBT_SHF_IR;
			SBT_EX1_IR: next_state = tms ? SBT_UPD_IR : SBT_PAU_IR;
			SBT_PAU_IR: next_state = tms ? SBT_EX2_IR : SBT_PAU_IR;
			SBT_EX2_IR: next_state = tms ? SBT_UPD_IR : SBT_SHF_IR;
			SBT_UPD_IR: next_state = tms ? SBT_SEL_DR : SBT_RTI;
		endcase
	end

	// State register, TMS sampled on rising edge
	always_ff @(posedge tck)
	begin
		if (por_sync)
			state <= SBT_TLR;
		else
			state <= next_state;
	end

	assign tap_state = state;

	// ==========================================================
	// Instruction register
	logic [SBT_IR_W-1:0] ir_shift;
	logic [SBT_IR_W-1:0] ir;
	logic [SBT_IR_W-1:0] next_ir_shift;
	logic [SBT_IR_W-1:0] next_ir;

	// Capture, shift and update of the instruction
	always_comb
	begin
		next_ir_shift = ir_shift;
		next_ir = ir;
		if (state == SBT_CAP_IR)
			next_ir_shift = SBT_IR_CAPTURE;
		else if (state == SBT_SHF_IR)
			next_ir_shift = {tdi, ir_shift[SBT_IR_W-1:1]};
		if (state == SBT_TLR)
			next_ir = SBT_INS_IDCODE;
		else if (state == SBT_UPD_IR)
			next_ir = ir_shift;
	end

	always_ff @(posedge tck)
	begin
		if (por_sync)
		begin
			ir_shift <= SBT_IR_CAPTURE;
			ir <= SBT_INS_IDCODE;
		end
		else
		begin
			ir_shift <= next_ir_shift;
			ir <= next_ir;
		end
	end

	// ==========================================================
	// Instruction decode, unknown codes fall to bypass
	logic sel_bsr;
	logic sel_id;
	logic sel_byp;
	logic extest_on;
	always_comb
	begin
		sel_bsr = (ir == SBT_INS_EXTEST) || (ir == SBT_INS_SAMPLE);
		sel_id = (ir == SBT_INS_IDCODE);
		sel_byp = !sel_bsr && !sel_id;
		extest_on = (next_ir == SBT_INS_EXTEST) && (next_state != SBT_TLR);
	end

	// ==========================================================
	// Drive mode held in a test clock flop before crossing
	logic drive_mode;
	logic next_drive_mode;

	// Decode glitches must not reach the synchroniser; follows state with no lag
	always_comb
	begin
		next_drive_mode = extest_on;
	end

	always_ff @(posedge tck)
	begin
		if (por_sync)
			drive_mode <= 1'b0;
		else
			drive_mode <= next_drive_mode;
	end

	// ==========================================================
	// Data registers
	sbt_idcode_t id_word;
	logic byp;
	logic [SBT_ID_W-1:0] id_shift;
	logic [SBT_BSR_W-1:0] bsr_shift;
	logic [SBT_BSR_W-1:0] bsr_upd;
	logic upd_toggle;
	logic next_byp;
	logic [SBT_ID_W-1:0] next_id_shift;
	logic [SBT_BSR_W-1:0] next_bsr_shift;
	logic [SBT_BSR_W-1:0] next_bsr_upd;
	logic next_upd_toggle;

	// Identity word layout
	always_comb
	begin
		id_word.revision = SBT_ID_REVISION;
		id_word.part = SBT_ID_PART;
		id_word.vendor = SBT_ID_VENDOR;
		id_word.fixed_one = 1'b1;
	end

	// Capture and shift of the selected data register
	always_comb
	begin
		next_byp = byp;
		next_id_shift = id_shift;
		next_bsr_shift = bsr_shift;
		next_bsr_upd = bsr_upd;
		next_upd_toggle = upd_toggle;
		if (state == SBT_CAP_DR)
		begin
			if (sel_byp)
				next_byp = 1'b0;
			if (sel_id)
				next_id_shift = id_word;
			if (sel_bsr)
				next_bsr_shift = ring_sync;
		end
		else if (state == SBT_SHF_DR)
		begin
			if (sel_byp)
				next_byp = tdi;
			if (sel_id)
				next_id_shift = {tdi, id_shift[SBT_ID_W-1:1]};
			if (sel_bsr)
				next_bsr_shift = {tdi, bsr_shift[SBT_BSR_W-1:1]};
		end
		else if (state == SBT_UPD_DR && sel_bsr)
		begin
			next_bsr_upd = bsr_shift;
			next_upd_toggle = !upd_toggle;
		end
	end

	always_ff @(posedge tck)
	begin
		if (por_sync)
		begin
			byp <= 1'b0;
			id_shift <= '0;
			bsr_shift <= '0;
			bsr_upd <= '0;
			upd_toggle <= 1'b0;
		end
		else
		begin
			byp <= next_byp;
			id_shift <= next_id_shift;
			bsr_shift <= next_bsr_shift;
			bsr_upd <= next_bsr_upd;
			upd_toggle <= next_upd_toggle;
		end
	end

	// ==========================================================
	// Serial output path, changes on falling edge
	logic serial_bit;
	logic shifting;
	logic next_tdo;
	logic next_tdo_oe_n;
	always_comb
	begin
		shifting = (state == SBT_SHF_IR) || (state == SBT_SHF_DR);
		if (state == SBT_SHF_IR)
			serial_bit = ir_shift[0];
		else if (sel_id)
			serial_bit = id_shift[0];
		else if (sel_bsr)
			serial_bit = bsr_shift[0];
		else
			serial_bit = byp;
		next_tdo = shifting ? serial_bit : 1'b0;
		next_tdo_oe_n = !shifting;
	end

	always_ff @(negedge tck)
	begin
		if (por_sync)
		begin
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end
		else
		begin
			tdo <= next_tdo;
			tdo_oe_n <= next_tdo_oe_n;
		end
	end

	// ==========================================================
	// Test vector crossing into the system clock domain
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_seen;
	logic ext_meta;
	logic ext_sync;
	logic [SBT_BSR_W-1:0] vec_hold;
	logic next_tgl_seen;
	logic [SBT_BSR_W-1:0] next_vec_hold;
	sbt_ring_t next_ring_test;

	// Synchronisers for update toggle and drive mode
	always_ff @(posedge clock)
	begin
		tgl_meta <= upd_toggle;
		tgl_sync <= tgl_meta;
		ext_meta <= drive_mode;
		ext_sync <= ext_meta;
	end

	// Update register stays put between toggles, so copy is safe
	always_comb
	begin
		next_tgl_seen = tgl_sync;
		next_vec_hold = vec_hold;
		if (tgl_sync != tgl_seen)
			next_vec_hold = bsr_upd;
		next_ring_test.value = next_vec_hold;
		next_ring_test.drive = ext_sync ? {SBT_BSR_W{1'b1}} : '0;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			tgl_seen <= 1'b0;
			vec_hold <= '0;
			ring_test <= '0;
		end
		else
		begin
			tgl_seen <= next_tgl_seen;
			vec_hold <= next_vec_hold;
			ring_test <= next_ring_test;
		end
	end

endmodule

// File: rtl/sbt_pkg.sv
// Functional notes
// - Only a reduced boundary-scan instruction subset is supported.
// - TMS and TDI are sampled on each rising test clock edge.
// - The serial test output changes only on the falling test clock edge.
// - Serial path depends on controller state and the held instruction.
// - No test reset pin; five high TMS edges reach test-logic-reset.
// - Power-up forces the controller into test-logic-reset.
// - The held instruction acts in run-test/idle and data register states.
// - A new instruction loads only while the instruction path is selected.
// - Instruction becomes identification at power-up and in test-logic-reset.
// - A one-bit bypass stage passes data with minimum delay.
// - Identification instruction plus capture-DR loads the 32-bit identity word.
// - The identity register then shifts between TDI and TDO in shift-DR.
// - Boundary selection plus capture-DR samples the present I/O ring values.
// - The boundary register then shifts between TDI and TDO in shift-DR.
// - Two instructions, external test and sample, select the boundary register.
// - Each boundary cell maps to one fixed bump by bit position.
// - Identity word: revision 31:28, part 27:12, vendor 11:1, bit 0 one.
// - External test drives preloaded vectors out and captures input responses.
package sbt_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned SBT_IR_W = 3;
	localparam int unsigned SBT_ID_W = 32;
	localparam int unsigned SBT_BSR_W = 107;

	// ==========================================================
	// Instruction codes
	localparam logic [2:0] SBT_INS_EXTEST = 3'h0;
	localparam logic [2:0] SBT_INS_IDCODE = 3'h1;
	localparam logic [2:0] SBT_INS_SAMPLE = 3'h4;
	localparam logic [2:0] SBT_INS_BYPASS = 3'h7;
	localparam logic [2:0] SBT_IR_CAPTURE = 3'h1;

	// ==========================================================
	// Identity word fields (values arbitrary)
	localparam logic [3:0] SBT_ID_REVISION = 4'h0;
	localparam logic [15:0] SBT_ID_PART = 16'h00a5;
	localparam logic [10:0] SBT_ID_VENDOR = 11'h05a;

	typedef struct packed {
		logic [3:0] revision;
		logic [15:0] part;
		logic [10:0] vendor;
		logic fixed_one;
	} sbt_idcode_t;

	// ==========================================================
	// Controller states
	typedef enum logic [3:0] {
		SBT_TLR, SBT_RTI, SBT_SEL_DR, SBT_CAP_DR, SBT_SHF_DR, SBT_EX1_DR,
		SBT_PAU_DR, SBT_EX2_DR, SBT_UPD_DR, SBT_SEL_IR, SBT_CAP_IR,
		SBT_SHF_IR, SBT_EX1_IR, SBT_PAU_IR, SBT_EX2_IR, SBT_UPD_IR
	} sbt_state_t;

	// Boundary ring pins, cell index = bit number
	typedef struct packed {
		logic [SBT_BSR_W-1:0] value;
		logic [SBT_BSR_W-1:0] drive;
	} sbt_ring_t;

endpackage

// File: verif/sbt_tap_properties.sv
module sbt_tap_properties (
	input wire logic clock, // Clock
	input wire logic reset, // Reset
	input wire logic tck, // Test clock
	input wire logic tms, // Mode
	input wire logic tdi, // Data in
	input wire logic tdo, // Data out
	input wire logic tdo_oe_n, // Enable
	input wire logic [sbt_pkg::SBT_BSR_W-1:0] ring_in, // Ring
	input sbt_pkg::sbt_ring_t ring_test, // Vector
	input sbt_pkg::sbt_state_t tap_state // State
);
	timeunit 1ns;
	timeprecision 100ps;
	import sbt_pkg::*;
	// Either shift state
	wire logic shifting = tap_state == SBT_SHF_DR || tap_state == SBT_SHF_IR;
	chk_oe_shift_only:
		assert property (@(posedge tck) disable iff (reset) tdo_oe_n == !shifting)
		else $error("enable outside shift");
	chk_idle_low:
		assert property (@(posedge tck) disable iff (reset) tdo_oe_n |-> !tdo)
		else $error("tdo not low when idle");
	chk_tdo_on_fall:
		assert property (@(tdo) disable iff (reset) tck)
		else $error("tdo moved off falling edge");
	chk_five_high:
		assert property (@(posedge tck) disable iff (reset) tms [*5] |=> tap_state == SBT_TLR)
		else $error("five high no reset");
	chk_exit_shift:
		assert property (@(posedge tck) disable iff (reset)
			tap_state == SBT_SHF_DR && tms |=> tap_state == SBT_EX1_DR)
		else $error("bad shift exit");
	chk_select_ir:
		assert property (@(posedge tck) disable iff (reset)
			tap_state == SBT_SEL_DR ##0 tms |=> tap_state == SBT_SEL_IR)
		else $error("bad select step");
	chk_id_first:
		assert property (@(posedge tck) disable iff (reset)
			tap_state == SBT_TLR ##1 tap_state == SBT_RTI ##1 tap_state == SBT_SEL_DR
			##1 tap_state == SBT_CAP_DR ##1 tap_state == SBT_SHF_DR |-> tdo)
		else $error("identity bit 0 not one");
	chk_drive_cleared:
		assert property (@(posedge clock) disable iff (reset)
			(tap_state == SBT_TLR) [*5] |-> ring_test.drive == '0)
		else $error("drive held in reset state");
	chk_drive_uniform:
		assert property (@(posedge clock) disable iff (reset)
			ring_test.drive == '0 || ring_test.drive == '1)
		else $error("drive mixed");
	cover property (@(posedge tck) tap_state == SBT_SHF_IR);
	cover property (@(posedge clock) ring_test.drive[0]);
	cover property (@(posedge tck) tms [*5]);
endmodule
bind sbt_tap sbt_tap_properties chk (.clock, .reset, .tck, .tms, .tdi, .tdo, .tdo_oe_n,
	.ring_in, .ring_test, .tap_state);

// File: verif/sbt_jtag_host.sv
module sbt_jtag_host (
	output logic tck, // Test clock
	output logic tms, // Mode
	output logic tdi, // Data in
	input wire logic tdo, // Data out
	input wire logic tdo_oe_n // Enable, low drives
);
	timeunit 1ns;
	timeprecision 100ps;
	// Released line floats
	wire logic tdo_line = tdo_oe_n ? 1'bz : tdo;
	// Clock stands low between frames
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One test clock pulse, steering by TMS only
	task automatic step(input logic m, input logic d, output logic o);
		#2;
		tms = m;
		tdi = d;
		#13;
		o = tdo_line;
		tck = 1'b1;
		#15;
		tck = 1'b0;
	endtask
	// Reset by holding TMS high
	task automatic idle5;
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
	endtask
	// Select, shift LSB first, update, idle
	task automatic scan(input logic ir, input int n, input logic [106:0] din,
		output logic [106:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b0, o);
		if (ir)
			step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule

// File: verif/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sbt_pkg::*;
	localparam logic [106:0] PAT = {11'h5a5, 32'hc3e1f00f, 64'h0123456789abcdef};
	logic clock;
	logic reset;
	logic [SBT_BSR_W-1:0] ring_in;
	logic tck, tms, tdi, tdo, tdo_oe_n, o;
	sbt_ring_t ring_test;
	sbt_state_t tap_state;
	logic [106:0] got;
	int n_fail;
	int n_compared;
	sbt_tap uut (.clock, .reset, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .ring_in, .ring_test,
		.tap_state);
	sbt_jtag_host host (.tck, .tms, .tdi, .tdo, .tdo_oe_n);
	// System clock
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic check(input logic [106:0] seen, input logic [106:0] want);
		n_compared++;
		if (seen !== want)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic finish_test;
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Reset for 6 clocks with TMS low, so only reset can reach TLR
	task automatic do_reset;
		@(posedge clock);
		#2 reset = 1'b1;
		fork
			repeat (6) @(posedge clock);
			repeat (8) host.step(1'b0, 1'b0, o);
		join
		#2 reset = 1'b0;
		repeat (3) host.step(1'b1, 1'b0, o);
	endtask
	// Identity word read from reset state
	task automatic t_idcode;
		check(107'(tap_state), 107'(SBT_TLR));
		host.step(1'b0, 1'b0, o);
		host.scan(1'b0, 32, '0, got);
		check(got[31:0], {SBT_ID_REVISION, SBT_ID_PART, SBT_ID_VENDOR, 1'b1});
	endtask
	// Bypass and unknown code
	task automatic t_bypass;
		logic [2:0] codes [2] = '{SBT_INS_BYPASS, 3'h2};
		foreach (codes[k])
		begin
			host.scan(1'b1, 3, 107'(codes[k]), got);
			check(got[2:0], SBT_IR_CAPTURE);
			host.scan(1'b0, 8, 107'h5c, got);
			check(got[7:0], 8'hb8);
		end
	endtask
	// Capture ring, shift vector, see it at pins
	task automatic t_ring(input logic [2:0] code, input logic [106:0] lvl, input logic drv);
		@(posedge clock);
		#2 ring_in = lvl;
		host.scan(1'b1, 3, 107'(code), got);
		host.scan(1'b0, SBT_BSR_W, ~lvl, got);
		check(got, lvl);
		repeat (6) @(posedge clock);
		#2;
		check(ring_test.value, ~lvl);
		check(ring_test.drive, {107{drv}});
	endtask
	// Five high TMS from mid-shift
	task automatic t_five;
		host.step(1'b1, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		host.idle5;
		check(107'(tap_state), 107'(SBT_TLR));
		repeat (6) @(posedge clock);
		#2;
		check(ring_test.drive, '0);
	endtask
	// Reset in the middle of an instruction shift
	task automatic t_mid;
		host.step(1'b1, 1'b0, o);
		host.step(1'b1, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		host.step(1'b0, 1'b0, o);
		#1;
		check(tdo_oe_n, 1'b0);
		do_reset;
		t_idcode;
	endtask
	initial
	begin
		reset = 1'b1;
		ring_in = '0;
		n_fail = 0;
		n_compared = 0;
		do_reset;
		t_idcode;
		t_bypass;
		t_ring(SBT_INS_SAMPLE, PAT, 1'b0);
		t_ring(SBT_INS_EXTEST, ~PAT, 1'b1);
		t_five;
		t_idcode;
		t_mid;
		finish_test;
	end
	// Hang limit
	initial
	begin
		repeat (20000) @(posedge clock);
		n_fail++;
		finish_test;
	end
endmodule
